/* core/angle_sensor_core.v */
// angle sensor digital core: front end, zero offset, serial slave, fuse
`include "angle_sensor_regs.vh"
`default_nettype none

// ==========================================================
// sample fifo
module sample_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW = 3
)
(
    input wire clock_i,
    input wire rst_n_i,
    input wire in_valid_i,
    input wire [WIDTH-1:0] in_data_i,
    output wire in_ready_o,
    output wire out_valid_o,
    output wire [WIDTH-1:0] out_data_o,
    input wire out_ready_i
);
    localparam integer DEPTH_INT = DEPTH;
    localparam [AW:0] DEPTH_COUNT = DEPTH_INT[AW:0];

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    assign in_ready_o = (count != DEPTH_COUNT);
    assign out_valid_o = (count != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always @(posedge clock_i)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// ==========================================================
// top: sensor core
module angle_sensor_core #(
    parameter SAMPLE_CYCLES = (`REFRESH_NS * `CLK_MHZ) / 1000,
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3
)
(
    input wire clock_i,
    input wire rst_n_i,
    input wire cs_n_i,
    input wire sclk_i,
    input wire mosi_i,
    output reg miso_o,
    output reg miso_oe_n_o,
    input wire sine_sign_i,
    input wire fuse_programming_supply_i,
    input wire fuse_blown_i,
    input wire [7:0] fuse_value_i,
    output reg fuse_burn_o,
    output reg [7:0] fuse_burn_data_o,
    output reg hall_u_o,
    output reg hall_v_o,
    output reg hall_w_o
);
    localparam integer REF_LAST_INT = SAMPLE_CYCLES - 1;
    localparam integer TDC_STEP_INT = 65536 / SAMPLE_CYCLES;
    localparam integer LAST_BIT_INT = `FRAME_BITS - 1;
    localparam [7:0] REF_LAST = REF_LAST_INT[7:0];
    localparam [15:0] TDC_STEP = TDC_STEP_INT[15:0];
    localparam [4:0] LAST_BIT = LAST_BIT_INT[4:0];
    localparam [4:0] FIRST_BYTE_LAST = 5'h07;

    // wrapping subtraction of an offset from the top raw byte
    function [7:0] offset_angle;
        input [7:0] raw;
        input [7:0] off;
        begin
            offset_angle = raw - off;
        end
    endfunction

    // commutation output is high across half a turn from its shift
    function hall_phase;
        input [7:0] ang;
        input [7:0] shift;
        reg [7:0] d;
        begin
            d = ang - shift;
            hall_phase = ~d[7];
        end
    endfunction

    // ======================================================
    // input synchronisers
    reg [2:0] cs_sync;
    reg [2:0] sclk_sync;
    reg [2:0] sine_sync;
    reg [1:0] mosi_sync;
    reg [1:0] supply_sync;

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cs_sync <= 3'b111;
            sclk_sync <= 3'b111;
            sine_sync <= 3'b000;
            mosi_sync <= 2'b00;
            supply_sync <= 2'b00;
        end
        else
        begin
            cs_sync <= {cs_sync[1:0], cs_n_i};
            sclk_sync <= {sclk_sync[1:0], sclk_i};
            sine_sync <= {sine_sync[1:0], sine_sign_i};
            mosi_sync <= {mosi_sync[0], mosi_i};
            supply_sync <= {supply_sync[0], fuse_programming_supply_i};
        end
    end

    wire cs_idle = cs_sync[1];
    wire cs_fall = ~cs_sync[1] & cs_sync[2];
    wire sclk_rise = sclk_sync[1] & ~sclk_sync[2];
    wire sclk_fall = ~sclk_sync[1] & sclk_sync[2];
    wire sine_rise = sine_sync[1] & ~sine_sync[2];

    // ======================================================
    // front end: time-to-digital phase measurement
    reg [7:0] ref_cnt;
    reg [15:0] phase;
    reg [15:0] measured;
    reg sample_pend;
    reg [15:0] raw_front_end_angle;
    wire ref_wrap = (ref_cnt == REF_LAST);
    wire fifo_in_ready;

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ref_cnt <= 8'h00;
            phase <= 16'h0000;
            measured <= 16'h0000;
            sample_pend <= 1'b0;
            raw_front_end_angle <= 16'h0000;
        end
        else
        begin
            if (ref_wrap)
            begin
                ref_cnt <= 8'h00;
                phase <= 16'h0000;
            end
            else
            begin
                ref_cnt <= ref_cnt + 8'h01;
                phase <= phase + TDC_STEP;
            end
            // delay from reference edge grows with clockwise rotation
            if (sine_rise)
            begin
                measured <= phase;
            end
            // a held sample waits for fifo room; a new one replaces it
            if (ref_wrap)
            begin
                sample_pend <= 1'b1;
                raw_front_end_angle <= measured;
            end
            else if (fifo_in_ready)
            begin
                sample_pend <= 1'b0;
            end
        end
    end

    // ======================================================
    // sample fifo and frozen output buffer
    wire fifo_out_valid;
    wire [15:0] fifo_out_data;
    reg [15:0] angle_buf;

    sample_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(sample_pend),
        .in_data_i(raw_front_end_angle),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(fifo_out_valid),
        .out_data_o(fifo_out_data),
        .out_ready_i(cs_idle)
    );

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            angle_buf <= 16'h0000;
        end
        else if (fifo_out_valid && cs_idle)
        begin
            angle_buf <= fifo_out_data;
        end
    end

    // ======================================================
    // registers and fuse store
    reg [7:0] zero_offset;
    reg fuse_locked;
    reg boot_done;
    reg frame_done;
    reg [15:0] frame_word;
    wire [3:0] frame_op = frame_word[15:12];
    wire [3:0] frame_addr = frame_word[11:8];
    wire [7:0] frame_data = frame_word[7:0];
    wire frame_write = frame_done && (frame_op == `OP_WRITE);

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            zero_offset <= `ZERO_OFFSET_RESET;
            fuse_locked <= 1'b0;
            boot_done <= 1'b0;
            fuse_burn_o <= 1'b0;
            fuse_burn_data_o <= 8'h00;
        end
        else
        begin
            fuse_burn_o <= 1'b0;
            if (!boot_done)
            begin
                boot_done <= 1'b1;
                if (fuse_blown_i)
                begin
                    zero_offset <= fuse_value_i;
                    fuse_locked <= 1'b1;
                end
            end
            else if (frame_write && !fuse_locked)
            begin
                if (frame_addr == `ADDR_ZERO_OFFSET)
                begin
                    zero_offset <= frame_data;
                end
                else if (frame_addr == `ADDR_FUSE_STORE
                         && frame_data[`FUSE_STORE_ZERO_BIT]
                         && supply_sync[1])
                begin
                    fuse_burn_o <= 1'b1;
                    fuse_burn_data_o <= zero_offset;
                    fuse_locked <= 1'b1;
                end
            end
        end
    end

    // read view of the register space
    function [7:0] reg_read;
        input [3:0] addr;
        begin
            case (addr)
                `ADDR_ZERO_OFFSET: reg_read = zero_offset;
                `ADDR_FUSE_STORE: reg_read =
                    {3'b000, fuse_locked, 4'h0};
                default: reg_read = `REG_UNMAPPED_VALUE;
            endcase
        end
    endfunction

    // ======================================================
    // serial slave, mode 3
    reg [15:0] rx_shift;
    reg [15:0] tx_shift;
    reg [4:0] bit_cnt;
    wire [7:0] out_angle = offset_angle(angle_buf[15:8], zero_offset);

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rx_shift <= 16'h0000;
            tx_shift <= 16'h0000;
            bit_cnt <= 5'h00;
            miso_o <= 1'b0;
            miso_oe_n_o <= 1'b1;
            frame_done <= 1'b0;
            frame_word <= 16'h0000;
        end
        else
        begin
            frame_done <= 1'b0;
            if (cs_idle)
            begin
                bit_cnt <= 5'h00;
                miso_oe_n_o <= 1'b1;
                miso_o <= 1'b0;
            end
            else if (cs_fall)
            begin
                // angle byte first, then the default second byte
                tx_shift <= {out_angle, `TX_SECOND_BYTE};
                miso_o <= out_angle[7];
                miso_oe_n_o <= 1'b0;
                bit_cnt <= 5'h00;
            end
            else
            begin
                if (sclk_fall)
                begin
                    miso_o <= tx_shift[15];
                    tx_shift <= {tx_shift[14:0], 1'b0};
                end
                if (sclk_rise && bit_cnt <= LAST_BIT)
                begin
                    rx_shift <= {rx_shift[14:0], mosi_sync[1]};
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt == FIRST_BYTE_LAST
                        && rx_shift[6:3] == `OP_READ)
                    begin
                        tx_shift[15:8] <=
                            reg_read({rx_shift[2:0], mosi_sync[1]});
                    end
                    if (bit_cnt == LAST_BIT)
                    begin
                        frame_done <= 1'b1;
                        frame_word <= {rx_shift[14:0], mosi_sync[1]};
                    end
                end
            end
        end
    end

    // ======================================================
    // commutation outputs
    wire [7:0] live_angle =
        offset_angle(raw_front_end_angle[15:8], zero_offset);

    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            hall_u_o <= 1'b0;
            hall_v_o <= 1'b0;
            hall_w_o <= 1'b0;
        end
        else
        begin
            hall_u_o <= hall_phase(live_angle, 8'h00);
            hall_v_o <= hall_phase(live_angle, `HALL_V_SHIFT);
            hall_w_o <= hall_phase(live_angle, `HALL_W_SHIFT);
        end
    end
endmodule

`default_nettype wire

/* core/angle_sensor_regs.vh */
// register map, field layout, reset values and timing counts of the sensor
`ifndef ANGLE_SENSOR_REGS_VH
`define ANGLE_SENSOR_REGS_VH

// ==========================================================
// register addresses and fields
`define ADDR_ZERO_OFFSET 4'h4
`define ADDR_FUSE_STORE 4'h9
`define FUSE_STORE_ZERO_BIT 4
`define ZERO_OFFSET_RESET 8'h00
`define REG_UNMAPPED_VALUE 8'h00

// ==========================================================
// frame opcodes and layout
`define OP_READ 4'h1
`define OP_WRITE 4'h2
`define FRAME_BITS 16
`define TX_SECOND_BYTE 8'h00

// ==========================================================
// timing
`define CLK_MHZ 25
`define REFRESH_NS 2000

// ==========================================================
// commutation phase shifts, 120 and 240 degrees in 1/256 turn
`define HALL_V_SHIFT 8'h55
`define HALL_W_SHIFT 8'hab

`endif

/* verification/spi_master_model.sv */
// serial master model driving mode-3 frames into the sensor core
`default_nettype none
module spi_master_model
(
    input wire logic clock_i,
    input wire logic miso_i,
    output var logic cs_n_o,
    output var logic sclk_o,
    output var logic mosi_o,
    output var logic done_o,
    output var logic [15:0] rx_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy = 1'b0;
    initial
    begin
        cs_n_o = 1'b1;
        sclk_o = 1'b1;
        mosi_o = 1'b0;
        done_o = 1'b0;
        rx_o = 16'h0000;
    end
    // mosi keeps changing while deselected so no stale bit looks valid
    always @(posedge clock_i)
        if (!busy)
            mosi_o <= ~mosi_o;
    // ==========
    // one full-duplex frame, called just after a clock edge
    task automatic frame(input logic [15:0] tx);
        integer i;
        begin
            busy = 1'b1;
            cs_n_o <= 1'b0;
            repeat (4) @(posedge clock_i);
            for (i = 15; i >= 0; i--)
            begin
                sclk_o <= 1'b0;
                mosi_o <= tx[i];
                repeat (4) @(posedge clock_i);
                sclk_o <= 1'b1;
                rx_o[i] <= miso_i;
                repeat (4) @(posedge clock_i);
            end
            cs_n_o <= 1'b1;
            done_o <= 1'b1;
            @(posedge clock_i);
            done_o <= 1'b0;
            busy = 1'b0;
            repeat (8) @(posedge clock_i);
        end
    endtask
endmodule
`default_nettype wire

/* verification/angle_sensor_core_props.sv */
// concurrent checks on the sensor core ports
`default_nettype none
module angle_sensor_checker
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic miso_o,
    input wire logic miso_oe_n_o,
    input wire logic fuse_programming_supply_i,
    input wire logic fuse_burn_o,
    input wire logic hall_u_o,
    input wire logic hall_v_o,
    input wire logic hall_w_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    // ==========
    // serial framing
    sequence s_sel_settled;
        !cs_n_i [*5];
    endsequence
    sequence s_desel_settled;
        cs_n_i [*5];
    endsequence
    a_oe_on_select: assert property (
        $fell(cs_n_i) |-> ##[2:3] !miso_oe_n_o)
        else $error("data-out not enabled after select");
    a_oe_off_deselect: assert property (
        $rose(cs_n_i) |-> ##[2:3] miso_oe_n_o)
        else $error("data-out not released after deselect");
    a_oe_in_frame: assert property (
        s_sel_settled |-> !miso_oe_n_o)
        else $error("data-out released inside frame");
    a_idle_line: assert property (
        s_desel_settled |-> miso_oe_n_o && !miso_o)
        else $error("data-out active while deselected");
    a_miso_hold: assert property (
        s_sel_settled ##0 (sclk_i && $past(sclk_i)) |-> $stable(miso_o))
        else $error("data-out moved while clock high");
    // ==========
    // fuse store and commutation
    a_burn_pulse: assert property (
        fuse_burn_o |=> !fuse_burn_o)
        else $error("burn strobe longer than one cycle");
    a_burn_supply: assert property (
        fuse_burn_o |-> fuse_programming_supply_i)
        else $error("burn without programming supply");
    a_hall_phases: assert property (
        $past(rst_n_i, 4) |-> !(hall_u_o == hall_v_o && hall_v_o == hall_w_o))
        else $error("commutation outputs in illegal state");
endmodule
bind angle_sensor_core angle_sensor_checker i_chk (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
    .sclk_i(sclk_i), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o),
    .fuse_programming_supply_i(fuse_programming_supply_i),
    .fuse_burn_o(fuse_burn_o), .hall_u_o(hall_u_o),
    .hall_v_o(hall_v_o), .hall_w_o(hall_w_o)
);
`default_nettype wire

/* verification/angle_sensor_core_bench.sv */
// self-checking bench for the sensor core with a serial master model
`include "angle_sensor_regs.vh"
`default_nettype none
`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); \
        end \
    end
module angle_sensor_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [15:0] val; logic [15:0] mask; bit hall;} note_t;
    localparam int samples = 50;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sine = 1'b0;
    logic supply = 1'b0;
    logic blown = 1'b0;
    logic [7:0] fval = 8'h00;
    wire cs_n, sclk, mosi, miso, miso_oe_n, burn, hall_u, hall_v, hall_w;
    wire done;
    wire [7:0] burn_data;
    wire [15:0] rx;
    int fails = 0;
    int tests_run = 0;
    int phase = 0;
    int i;
    note_t notes[$];
    note_t n;
    logic [7:0] a0, z, v, hv, hw;
    logic [2:0] hexp;
    logic [31:0] seed = 32'h0000_230a;
    angle_sensor_core #(.SAMPLE_CYCLES(samples)) i_dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n),
        .sclk_i(sclk), .mosi_i(mosi), .miso_o(miso),
        .miso_oe_n_o(miso_oe_n), .sine_sign_i(sine),
        .fuse_programming_supply_i(supply), .fuse_blown_i(blown),
        .fuse_value_i(fval), .fuse_burn_o(burn),
        .fuse_burn_data_o(burn_data), .hall_u_o(hall_u),
        .hall_v_o(hall_v), .hall_w_o(hall_w)
    );
    spi_master_model i_master (
        .clock_i(clock_i), .miso_i(miso), .cs_n_o(cs_n), .sclk_o(sclk),
        .mosi_o(mosi), .done_o(done), .rx_o(rx)
    );
    initial
        forever #20 clock_i = ~clock_i;
    // field phase locked to the sample period keeps the raw angle constant
    always @(posedge clock_i)
    begin
        phase <= (!rst_n_i || phase == samples - 1) ? 0 : phase + 1;
        sine <= phase < 25;
    end
    // ==========
    // result monitor
    always @(posedge clock_i)
        if (done === 1'b1)
        begin
            n = notes.pop_front();
            `CHK(rx & n.mask, n.val & n.mask)
            hv = n.val[15:8] - `HALL_V_SHIFT;
            hw = n.val[15:8] - `HALL_W_SHIFT;
            hexp = ~{n.val[15], hv[7], hw[7]};
            if (n.hall)
                `CHK({hall_u, hall_v, hall_w}, hexp)
        end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        begin
            x = s ^ (s << 13);
            x = x ^ (x >> 17);
            xs = x ^ (x << 5);
        end
    endfunction
    task automatic close_out();
        begin
            if (fails == 0 && tests_run > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task automatic xfer(input logic [15:0] tx, input logic [15:0] val,
                        input logic [15:0] mask, input bit hall);
        begin
            notes.push_back('{val, mask, hall});
            i_master.frame(tx);
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] d);
        xfer({`OP_READ, a, 8'h00}, {a0 - z, d}, 16'hffff, 1);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        xfer({`OP_WRITE, a, d}, {a0 - z, `TX_SECOND_BYTE}, 16'hffff, 0);
    endtask
    task automatic boot(input logic b, input logic [7:0] val);
        begin
            rst_n_i <= 1'b0;
            blown <= b;
            fval <= val;
            repeat (6) @(posedge clock_i);
            rst_n_i <= 1'b1;
            repeat (200) @(posedge clock_i);
        end
    endtask
    // ==========
    // scenarios
    initial
    begin
        boot(1'b0, 8'h00);
        z = `ZERO_OFFSET_RESET;
        xfer({`OP_READ, `ADDR_ZERO_OFFSET, 8'h00}, 0, 16'h00ff, 0);
        a0 = rx[15:8];
        for (i = 0; i < 5; i++)
        begin
            seed = xs(seed);
            v = (i == 0) ? 8'hff : seed[7:0];
            wr(`ADDR_ZERO_OFFSET, v);
            z = v;
            rd(`ADDR_ZERO_OFFSET, z);
        end
        rd(4'h7, `REG_UNMAPPED_VALUE);
        rd(`ADDR_FUSE_STORE, 8'h00);
        for (i = 0; i < 16; i++)
            if (i != 1 && i != 2)
                xfer({i[3:0], 4'h4, ~z}, {a0 - z, 8'h00}, 16'hffff, 0);
        rd(`ADDR_ZERO_OFFSET, z);
        supply <= 1'b1;
        repeat (4) @(posedge clock_i);
        fork
            wr(`ADDR_FUSE_STORE, 8'h10);
            begin
                repeat (300)
                begin
                    @(posedge clock_i);
                    if (burn === 1'b1)
                        break;
                end
                `CHK(burn, 1'b1)
                `CHK(burn_data, z)
            end
        join
        supply <= 1'b0;
        wr(`ADDR_ZERO_OFFSET, z + 8'h11);
        rd(`ADDR_ZERO_OFFSET, z);
        rd(`ADDR_FUSE_STORE, 8'h10);
        seed = xs(seed);
        v = seed[7:0];
        boot(1'b1, v);
        z = v;
        rd(`ADDR_ZERO_OFFSET, z);
        wr(`ADDR_ZERO_OFFSET, ~z);
        rd(`ADDR_ZERO_OFFSET, z);
        close_out();
    end
    initial
    begin
        #(20000 * 40);
        fails++;
        close_out();
    end
endmodule
`default_nettype wire
